// [rtl/oft_overload_timer.sv]
`timescale 1ns/1ps
module oft_overload_timer import oft_pkg::*; #(
    parameter int N_CH = 8,
    parameter int CNT_W = 16,
    parameter int TICK_CYCLES = OFT_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire oft_wb_req_t wb_req,
    output oft_wb_rsp_t wb_rsp,
    input wire logic [N_CH-1:0] chan_powered,
    input wire logic [N_CH-1:0] inrush_fault_window_expired,
    input wire logic [N_CH-1:0] above_power_cut_threshold,
    input wire logic [N_CH-1:0] foldback_active,
    input wire logic [N_CH-1:0] power_enable_off,
    input wire logic [N_CH-1:0] reset_command,
    input wire logic [N_CH-1:0] dc_disconnect,
    input wire logic [N_CH-1:0] fast_shutdown_input,
    input wire logic [N_CH-1:0][1:0] chan_mode,
    input wire logic [N_CH-1:0] detect_enable,
    output logic [N_CH-1:0] chan_cut_off,
    output logic [N_CH-1:0] turn_on_blocked,
    output logic [N_CH-1:0] detect_restart,
    output logic irq
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int SW = 2 * N_CH;

    typedef struct packed {
        oft_wb_rsp_t rsp;
        logic [TW-1:0] tick_cnt;
        logic [3:0] sub;
        logic [7:0] timing;
        logic [N_CH-1:0] cutdis;
        logic [SW-1:0] status;
        logic [SW-1:0] mask;
        oft_ch_state_t [N_CH-1:0] st;
        logic [N_CH-1:0][CNT_W-1:0] cnt;
        logic [N_CH-1:0][CNT_W-1:0] cool;
        logic [N_CH-1:0] cut;
        logic [N_CH-1:0] blocked;
        logic [N_CH-1:0] restart;
        logic irq;
    } oft_state_t;

    oft_state_t s;
    oft_state_t next_s;

    logic req;
    logic fire;
    logic tick;
    logic dec_tick;
    logic overload_timeout_select_chg;
    logic [31:0] lanes;
    logic [31:0] rd;
    logic [SW-1:0] set_v;
    logic [SW-1:0] clr_v;
    logic [N_CH-1:0] inc_v;
    logic [N_CH-1:0] zero_v;
    logic [N_CH-1:0] cancel_v;
    logic [N_CH-1:0] off_v;
    logic [CNT_W-1:0] limit;

    function automatic logic [31:0] oft_lanes(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // Code zero gives the nominal duration, the others are scaled around it
    function automatic logic [CNT_W-1:0] oft_limit(input logic [1:0] code);
        case (code)
            2'h0: return CNT_W'(OFT_OVLD_MS0 / OFT_TICK_MS);
            2'h1: return CNT_W'(OFT_OVLD_MS1 / OFT_TICK_MS);
            2'h2: return CNT_W'(OFT_OVLD_MS2 / OFT_TICK_MS);
            default: return CNT_W'(OFT_OVLD_MS3 / OFT_TICK_MS);
        endcase
    endfunction

    always_comb begin
        next_s = s;
        req = wb_req.cyc && wb_req.stb;
        fire = req && s.rsp.ack;
        lanes = oft_lanes(wb_req.sel);
        rd = '0;
        set_v = '0;
        clr_v = '0;
        overload_timeout_select_chg = 1'b0;
        inc_v = '0;
        zero_v = '0;
        cancel_v = '0;
        off_v = '0;
        limit = oft_limit(s.timing[OFT_OVERLOAD_TIMEOUT_SELECT_MSB:OFT_OVERLOAD_TIMEOUT_SELECT_LSB]);
        next_s.rsp.ack = 1'b0;
        next_s.cut = '0;
        next_s.restart = '0;

        tick = s.tick_cnt == TW'(TICK_CYCLES - 1);
        dec_tick = tick && (s.sub == 4'(OFT_DEC_RATIO - 1));
        if (tick) begin
            next_s.tick_cnt = '0;
            next_s.sub = s.sub + 4'h1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + TW'(1);
        end

        for (int i = 0; i < N_CH; i++) begin
            zero_v[i] = s.cnt[i] == '0;
        end
        case (wb_req.adr)
            OFT_ADR_TIMING: rd[7:0] = s.timing;
            OFT_ADR_CUTDIS: rd[N_CH-1:0] = s.cutdis;
            OFT_ADR_STATUS: rd[SW-1:0] = s.status;
            OFT_ADR_MASK: rd[SW-1:0] = s.mask;
            OFT_ADR_STATE: rd[SW-1:0] = {~zero_v, s.blocked};
            default: rd = '0;
        endcase
        // Read data is latched with ack so it stands for the whole answer cycle
        if (req && !s.rsp.ack) begin
            next_s.rsp.ack = 1'b1;
            next_s.rsp.dat = rd;
        end

        if (fire && wb_req.we) begin
            case (wb_req.adr)
                OFT_ADR_TIMING: begin
                    next_s.timing = (s.timing & ~lanes[7:0]) | (wb_req.dat[7:0] & lanes[7:0]);
                    overload_timeout_select_chg = next_s.timing[OFT_OVERLOAD_TIMEOUT_SELECT_MSB:OFT_OVERLOAD_TIMEOUT_SELECT_LSB]
                        != s.timing[OFT_OVERLOAD_TIMEOUT_SELECT_MSB:OFT_OVERLOAD_TIMEOUT_SELECT_LSB];
                end
                OFT_ADR_CUTDIS: begin
                    next_s.cutdis = (s.cutdis & ~lanes[N_CH-1:0]) | (wb_req.dat[N_CH-1:0] & lanes[N_CH-1:0]);
                end
                OFT_ADR_STATUS: clr_v = wb_req.dat[SW-1:0] & lanes[SW-1:0];
                OFT_ADR_MASK: begin
                    next_s.mask = (s.mask & ~lanes[SW-1:0]) | (wb_req.dat[SW-1:0] & lanes[SW-1:0]);
                end
                default: ;
            endcase
        end

        for (int i = 0; i < N_CH; i++) begin
            inc_v[i] = chan_powered[i] && inrush_fault_window_expired[i]
                && (above_power_cut_threshold[i] || foldback_active[i]);
            off_v[i] = power_enable_off[i] || reset_command[i] || dc_disconnect[i] || fast_shutdown_input[i];
            cancel_v[i] = reset_command[i] || (chan_mode[i] == OFT_MODE_OFF)
                || (chan_mode[i] == OFT_MODE_MANUAL);
            case (s.st[i])
                OFT_CH_RUN: begin
                    if (off_v[i]) begin
                        next_s.cnt[i] = '0;
                    end else if (overload_timeout_select_chg) begin
                        next_s.cnt[i] = '0;
                    end else if (inc_v[i]) begin
                        if (tick && (s.cnt[i] + CNT_W'(1) >= limit)) begin
                            set_v[i] = 1'b1;
                            next_s.cnt[i] = '0;
                            // With cut-off disabled the fault is flagged and the timer simply restarts
                            if (!s.cutdis[i]) begin
                                next_s.cut[i] = 1'b1;
                                next_s.st[i] = OFT_CH_COOL;
                                next_s.cool[i] = '0;
                            end
                        end else if (tick) begin
                            next_s.cnt[i] = s.cnt[i] + CNT_W'(1);
                        end
                    end else if (dec_tick && !zero_v[i]) begin
                        next_s.cnt[i] = s.cnt[i] - CNT_W'(1);
                    end
                end
                OFT_CH_COOL: begin
                    next_s.cnt[i] = '0;
                    if (cancel_v[i]) begin
                        next_s.st[i] = OFT_CH_RUN;
                    end else if (tick && (s.cool[i] == CNT_W'(OFT_COOL_TICKS - 1))) begin
                        next_s.st[i] = OFT_CH_RUN;
                        set_v[N_CH + i] = 1'b1;
                        next_s.restart[i] = (chan_mode[i] == OFT_MODE_SEMI) && detect_enable[i];
                    end else if (tick) begin
                        next_s.cool[i] = s.cool[i] + CNT_W'(1);
                    end
                end
                default: next_s.st[i] = OFT_CH_RUN;
            endcase
            next_s.blocked[i] = next_s.st[i] == OFT_CH_COOL;
        end

        // A new event wins over a clear in the same cycle
        next_s.status = (s.status & ~clr_v) | set_v;
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.timing <= OFT_TIMING_RST;
            s.st <= {N_CH{OFT_CH_RUN}};
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp = s.rsp;
    assign chan_cut_off = s.cut;
    assign turn_on_blocked = s.blocked;
    assign detect_restart = s.restart;
    assign irq = s.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held longer than one cycle");

    a_ack_answer: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("request not answered in one cycle");

    a_ack_idle: assert property (!req |=> !wb_rsp.ack)
        else $error("ack without request");

    a_timing_write: assert property (fire && wb_req.we && wb_req.adr == OFT_ADR_TIMING && wb_req.sel[0]
        |=> s.timing == $past(wb_req.dat[7:0]))
        else $error("timing write lost");

    a_cut_cools: assert property (chan_cut_off[0] |-> turn_on_blocked[0] && !$past(s.cutdis[0]))
        else $error("cut-off without cool-down or while disabled");

    a_cool_holds: assert property (turn_on_blocked[0] && !cancel_v[0] && !tick |=> turn_on_blocked[0])
        else $error("cool-down ended early");

    a_inc_gated: assert property (s.st[0] == OFT_CH_RUN && !inc_v[0] |=> s.cnt[0] <= $past(s.cnt[0]))
        else $error("counter rose without overload");

    a_inc_tick: assert property (!tick |=> s.cnt[0] <= $past(s.cnt[0]))
        else $error("counter rose off a tick");

    a_dec_floor: assert property (s.cnt[0] == '0 && !(inc_v[0] && tick) |=> s.cnt[0] == '0)
        else $error("counter left zero without increment");

    a_dec_step: assert property (s.st[0] == OFT_CH_RUN && !inc_v[0] && !off_v[0] && !overload_timeout_select_chg
        |=> 32'(s.cnt[0]) + 1 >= 32'($past(s.cnt[0])))
        else $error("counter fell by more than one");

    a_dec_slow: assert property (s.st[0] == OFT_CH_RUN && !inc_v[0] && !off_v[0] && !overload_timeout_select_chg && !dec_tick
        |=> s.cnt[0] == $past(s.cnt[0]))
        else $error("counter fell off the slow tick");

    a_clear_off: assert property (off_v[0] |=> s.cnt[0] == '0)
        else $error("counter not cleared on turn-off");

    a_overload_timeout_select_restart: assert property (overload_timeout_select_chg |=> s.cnt[0] == '0)
        else $error("timer not restarted on time-out change");

    a_restart_semi: assert property (detect_restart[0] |-> $past(chan_mode[0]) == OFT_MODE_SEMI
        && $past(detect_enable[0]))
        else $error("detection restarted outside semi-auto");

    a_restart_after: assert property (detect_restart[0] |-> $past(turn_on_blocked[0]))
        else $error("detection restarted without cool-down");

    a_restart_pulse: assert property (detect_restart[0] |=> !detect_restart[0])
        else $error("restart pulse stretched");

    a_cancel_cool: assert property (turn_on_blocked[0] && cancel_v[0] |=> !turn_on_blocked[0])
        else $error("cool-down not cancelled");

    a_nocut_fault: assert property (s.cutdis[0] && set_v[0] |=> !chan_cut_off[0] && s.status[0])
        else $error("disabled channel was cut or fault lost");

    a_cutdis_keep: assert property (s.cutdis[0] && !turn_on_blocked[0] |=> !turn_on_blocked[0])
        else $error("disabled channel entered cool-down");

    a_status_sticky: assert property (s.status[0] && !clr_v[0] |=> s.status[0])
        else $error("fault bit dropped without clear");

    a_status_set: assert property (set_v[0] |=> s.status[0])
        else $error("fault bit not set on expiry");

    a_cut_status: assert property (chan_cut_off[0] |-> s.status[0])
        else $error("cut-off without fault bit");

    a_cut_pulse: assert property (chan_cut_off[0] |=> !chan_cut_off[0])
        else $error("cut-off pulse stretched");

    a_cool_zero: assert property (turn_on_blocked[0] |-> s.cnt[0] == '0)
        else $error("counter running during cool-down");

    a_block_entry: assert property (!turn_on_blocked[0] ##1 turn_on_blocked[0] |-> chan_cut_off[0])
        else $error("cool-down began without cut-off");

    a_cools_one: assert property (chan_cut_off[1] |-> turn_on_blocked[1] && !$past(s.cutdis[1]))
        else $error("cut-off without cool-down or while disabled");

    a_holds_one: assert property (turn_on_blocked[1] && !cancel_v[1] && !tick |=> turn_on_blocked[1])
        else $error("cool-down ended early");

    a_gated_one: assert property (s.st[1] == OFT_CH_RUN && !inc_v[1] |=> s.cnt[1] <= $past(s.cnt[1]))
        else $error("counter rose without overload");

    a_step_one: assert property (!tick |=> s.cnt[1] <= $past(s.cnt[1]))
        else $error("counter rose off a tick");

    a_floor_one: assert property (s.cnt[1] == '0 && !(inc_v[1] && tick) |=> s.cnt[1] == '0)
        else $error("counter left zero without increment");

    a_slow_one: assert property (s.st[1] == OFT_CH_RUN && !inc_v[1] && !off_v[1] && !overload_timeout_select_chg && !dec_tick
        |=> s.cnt[1] == $past(s.cnt[1]))
        else $error("counter fell off the slow tick");

    a_clear_one: assert property (off_v[1] |=> s.cnt[1] == '0)
        else $error("counter not cleared on turn-off");

    a_overload_timeout_select_one: assert property (overload_timeout_select_chg |=> s.cnt[1] == '0)
        else $error("timer not restarted on time-out change");

    a_semi_one: assert property (detect_restart[1] |-> $past(chan_mode[1]) == OFT_MODE_SEMI
        && $past(detect_enable[1]))
        else $error("detection restarted outside semi-auto");

    a_restart_one: assert property (detect_restart[1] |=> !detect_restart[1])
        else $error("restart pulse stretched");

    a_cancel_one: assert property (turn_on_blocked[1] && cancel_v[1] |=> !turn_on_blocked[1])
        else $error("cool-down not cancelled");

    a_nocut_one: assert property (s.cutdis[1] && set_v[1] |=> !chan_cut_off[1] && s.status[1])
        else $error("disabled channel was cut or fault lost");

    a_keep_one: assert property (s.cutdis[1] && !turn_on_blocked[1] |=> !turn_on_blocked[1])
        else $error("disabled channel entered cool-down");

    a_sticky_one: assert property (s.status[1] && !clr_v[1] |=> s.status[1])
        else $error("fault bit dropped without clear");

    a_pulse_one: assert property (chan_cut_off[1] |=> !chan_cut_off[1])
        else $error("cut-off pulse stretched");

    a_zero_one: assert property (turn_on_blocked[1] |-> s.cnt[1] == '0)
        else $error("counter running during cool-down");

    a_entry_one: assert property (!turn_on_blocked[1] ##1 turn_on_blocked[1] |-> chan_cut_off[1])
        else $error("cool-down began without cut-off");

endmodule // oft_overload_timer

// [rtl/oft_pkg.sv]
package oft_pkg;

    localparam int OFT_CLK_PERIOD_NS = 5;
    localparam int OFT_TICK_NS = 1000000;
    localparam int OFT_TICK_CYCLES = OFT_TICK_NS / OFT_CLK_PERIOD_NS;
    localparam int OFT_TICK_MS = 1;
    localparam int OFT_COOL_MS = 1000;
    localparam int OFT_COOL_TICKS = OFT_COOL_MS / OFT_TICK_MS;
    localparam int OFT_DEC_RATIO = 16;
    localparam int OFT_OVLD_MS0 = 60;
    localparam int OFT_OVLD_MS1 = 30;
    localparam int OFT_OVLD_MS2 = 120;
    localparam int OFT_OVLD_MS3 = 240;

    localparam logic [7:0] OFT_ADR_TIMING = 8'h00;
    localparam logic [7:0] OFT_ADR_CUTDIS = 8'h04;
    localparam logic [7:0] OFT_ADR_STATUS = 8'h08;
    localparam logic [7:0] OFT_ADR_MASK = 8'h0C;
    localparam logic [7:0] OFT_ADR_STATE = 8'h10;

    localparam int OFT_OVERLOAD_TIMEOUT_SELECT_LSB = 2;
    localparam int OFT_OVERLOAD_TIMEOUT_SELECT_MSB = 3;
    localparam logic [7:0] OFT_TIMING_RST = 8'h00;

    typedef enum logic [1:0] {
        OFT_MODE_OFF = 2'h0,
        OFT_MODE_MANUAL = 2'h1,
        OFT_MODE_SEMI = 2'h2,
        OFT_MODE_AUTO = 2'h3
    } oft_mode_t;

    typedef enum logic [1:0] {
        OFT_CH_RUN = 2'b01,
        OFT_CH_COOL = 2'b10
    } oft_ch_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } oft_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } oft_wb_rsp_t;

endpackage

// [test/oft_overload_timer_tb.sv]
`timescale 1ns/1ps
module oft_overload_timer_tb import oft_pkg::*;;
    localparam int N = 2;
    localparam int TK = 4;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    oft_wb_req_t req = '0;
    oft_wb_rsp_t rsp;
    logic [N-1:0] pw = '0, inr = '0, abv = '0, fb = '0, det = '0;
    logic [3:0][N-1:0] clr = '0;
    logic [N-1:0][1:0] mode = '0;
    logic [N-1:0] cut, blk, restart;
    logic irq;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_cut = 0;
    int n_rst = 0;

    oft_overload_timer #(.N_CH(N), .CNT_W(16), .TICK_CYCLES(TK)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .wb_req(req), .wb_rsp(rsp), .chan_powered(pw), .inrush_fault_window_expired(inr),
        .above_power_cut_threshold(abv), .foldback_active(fb), .power_enable_off(clr[0]),
        .reset_command(clr[1]), .dc_disconnect(clr[2]), .fast_shutdown_input(clr[3]), .chan_mode(mode),
        .detect_enable(det), .chan_cut_off(cut), .turn_on_blocked(blk), .detect_restart(restart), .irq(irq));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Pulses are counted per cycle, so a stretched pulse shows up
    always @(posedge ref_clk) begin
        if (cut[0] === 1'b1) n_cut++;
        if (restart[0] === 1'b1) n_rst++;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
        for (k = 0; k < 20 && rsp.ack !== 1'b1; k++) begin
            @(posedge ref_clk);
        end
        if (k >= 20) n_mismatch++;
        rd = rsp.dat;
        req <= '0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(nm, rd, exp);
    endtask

    // Delay in cycles until the watched output rises must fall in (lo, hi + 1]
    task automatic wait_for(input int sel, input int lo, input int hi);
        int k;
        logic hit;
        hit = 1'b0;
        for (k = 0; k <= hi && hit !== 1'b1; k++) begin
            @(posedge ref_clk);
            hit = (sel == 0) ? cut[0] : (sel == 1) ? restart[0] : irq;
        end
        chk("event delay", {31'h0, hit === 1'b1 && k > lo}, 32'h1);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rdchk("timing", OFT_ADR_TIMING, 32'h0);
        rdchk("cutdis", OFT_ADR_CUTDIS, 32'h0);
        rdchk("status", OFT_ADR_STATUS, 32'h0);
        rdchk("state", OFT_ADR_STATE, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        wb(1'b1, OFT_ADR_TIMING, 32'h04);
        rdchk("timing", OFT_ADR_TIMING, 32'h04);
        wb(1'b1, OFT_ADR_MASK, 32'h0F);
        $display("test registers finished");
        // Channel 1 has no expired inrush window, so it must never count
        mode <= {OFT_MODE_SEMI, OFT_MODE_SEMI};
        det <= 2'b11;
        pw <= 2'b11;
        abv <= 2'b11;
        inr <= 2'b01;
        wait_for(0, 4 * 29 - 1, 4 * 30 + 3);
        chk("blocked", {30'h0, blk}, 32'h1);
        pw <= 2'b00;
        abv <= 2'b00;
        rdchk("status", OFT_ADR_STATUS, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        wait_for(1, 4 * 1000 - 8, 4 * 1000 + 8);
        rdchk("status", OFT_ADR_STATUS, 32'h5);
        chk("pulses", n_cut * 16 + n_rst, 32'h11);
        wb(1'b1, OFT_ADR_STATUS, 32'h0F);
        rdchk("status", OFT_ADR_STATUS, 32'h0);
        pw <= 2'b01;
        abv <= 2'b01;
        wait_for(0, 4 * 29 - 1, 4 * 30 + 3);
        pw <= 2'b00;
        abv <= 2'b00;
        mode[0] <= OFT_MODE_MANUAL;
        repeat (3) @(posedge ref_clk);
        chk("blocked", {30'h0, blk}, 32'h0);
        rdchk("status", OFT_ADR_STATUS, 32'h1);
        wb(1'b1, OFT_ADR_STATUS, 32'h0F);
        mode[0] <= OFT_MODE_SEMI;
        $display("test cool-down finished");
        wb(1'b1, OFT_ADR_CUTDIS, 32'h1);
        pw <= 2'b01;
        fb <= 2'b01;
        wait_for(2, 4 * 29 - 1, 4 * 30 + 3);
        chk("cut count", n_cut, 32'h2);
        chk("blocked", {30'h0, blk}, 32'h0);
        fb <= 2'b00;
        wb(1'b1, OFT_ADR_STATUS, 32'h0F);
        $display("test cut-off disable finished");
        // Rewrite after 20 ticks: old setting would expire much sooner
        abv <= 2'b01;
        repeat (20 * TK) @(posedge ref_clk);
        wb(1'b1, OFT_ADR_TIMING, 32'h00);
        wait_for(2, 4 * 59 - 8, 4 * 60 + 3);
        abv <= 2'b00;
        wb(1'b1, OFT_ADR_STATUS, 32'h0F);
        repeat (70 * TK) @(posedge ref_clk);
        $display("test rewrite finished");
        for (int k = 0; k < 4; k++) begin
            abv <= 2'b01;
            repeat (3 * TK) @(posedge ref_clk);
            abv <= 2'b00;
            rdchk("state", OFT_ADR_STATE, 32'h4);
            clr[k][0] <= 1'b1;
            @(posedge ref_clk);
            clr[k][0] <= 1'b0;
            rdchk("state", OFT_ADR_STATE, 32'h0);
        end
        abv <= 2'b01;
        repeat (3 * TK) @(posedge ref_clk);
        abv <= 2'b00;
        repeat (14 * TK) @(posedge ref_clk);
        rdchk("state", OFT_ADR_STATE, 32'h4);
        repeat (5 * 16 * TK) @(posedge ref_clk);
        rdchk("state", OFT_ADR_STATE, 32'h0);
        $display("test clear and decay finished");
        print_verdict();
    end
endmodule // oft_overload_timer_tb
